// ==== hdl/fault_trace_exc.sv ====
// Instruction fault and trace exception unit: picks vectors, updates status, builds frames.
// Assumes the decoder offers one instruction at a time and holds it until accepted.
`timescale 1ns/1ps
`default_nettype none
module fault_trace_exc
   import fault_trace_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           arst_n,
   input  wire instr_info_type instr,
   input  wire logic           instr_start,
   input  wire logic           instr_done,
   input  wire logic           instr_suspend,
   input  wire logic           forced_exc,
   input  wire logic           irq_pending,
   input  wire logic           stop_sr_load,
   input  wire logic [15:0]    stop_sr_value,
   input  wire logic           bkpt_ack_cycle,
   input  wire logic           transfer_done_ack,
   input  wire logic           transfer_fault_ack,
   input  wire logic [3:0]     return_format,
   input  wire logic           format_valid,
   input  wire logic [31:0]    vector_table_base,
   input  wire logic           frame_ack,
   output logic                instr_accept,
   output logic                instr_skip,
   output logic                irq_grant,
   output logic                stop_enter,
   output logic [15:0]         processor_status_word,
   output logic                trace_select_high,
   output logic                trace_select_low,
   output exc_frame_type       frame_out,
   output logic                busy
);
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_STACK = 3'b100
   } state_type;

   state_type      state_r, state_nxt;
   logic [15:0]    sr_r, sr_nxt;
   logic [1:0]     tsel_r, tsel_nxt;
   logic           flow_r, flow_nxt;
   logic           stop_r, stop_nxt;
   logic           trace_due_r, trace_due_nxt;
   logic [31:0]    next_pc_r, next_pc_nxt;
   exc_frame_type  frame_r, frame_nxt;
   logic           accept_r, skip_r, grant_r, stopped_r;
   logic           accept_nxt, skip_nxt, grant_nxt, stopped_nxt;

   wire            cls_fault;
   wire [7:0]      cls_vec;
   wire            cls_fp;
   wire            trace_hit;

   opcode_classifier u_cls (
      .instr      (instr),
      .super_mode (sr_r[SR_SUPER]),
      .fault      (cls_fault),
      .vector     (cls_vec),
      .fp_frame   (cls_fp)
   );

   trace_qualifier u_trq (
      .tsel        (tsel_r),
      .flow_change (flow_r | stop_r),
      .take_trace  (trace_hit)
   );

   // Event decoding
   wire bkpt_end   = bkpt_ack_cycle && (transfer_done_ack || transfer_fault_ack);
   wire fmt_bad    = instr.valid && instr.is_exc_return && !format_valid;
   wire start_ok   = state_r == ST_IDLE && instr_start && instr.valid;
   wire exc_sr_tr  = 1'b1;
   wire [15:0] sr_enter = {2'b00, exc_sr_tr, sr_r[12:0]}; // Supervisor set, trace cleared
   wire [31:0] base     = vector_table_base;

   // Builds one frame record from vector, stacked pc and operand address
   function automatic exc_frame_type mk_frame(input logic [7:0]  vec,
                                              input logic [3:0]  fmt,
                                              input logic [31:0] spc,
                                              input logic [31:0] fpc,
                                              input logic [31:0] ea,
                                              input logic [15:0] sr,
                                              input logic [31:0] vbase);
      mk_frame.valid        = 1'b1;
      mk_frame.vector       = vec;
      mk_frame.frame        = fmt;
      mk_frame.stacked_pc   = spc;
      mk_frame.fault_pc     = fpc;
      mk_frame.ea           = ea;
      mk_frame.saved_sr     = sr;
      mk_frame.handler_addr = vector_addr(vbase, vec);
   endfunction : mk_frame

   // Sequencer next state
   always_comb begin
      state_nxt     = state_r;
      sr_nxt        = sr_r;
      tsel_nxt      = tsel_r;
      flow_nxt      = flow_r;
      stop_nxt      = stop_r;
      trace_due_nxt = trace_due_r;
      next_pc_nxt   = next_pc_r;
      frame_nxt     = frame_r;
      accept_nxt    = 1'b0;
      skip_nxt      = 1'b0;
      grant_nxt     = 1'b0;
      stopped_nxt   = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (bkpt_end) begin
               frame_nxt = mk_frame(VEC_ILLEGAL, FRAME_SHORT, instr.pc, instr.pc,
                                    32'h0000_0000, sr_r, base);
               sr_nxt    = sr_enter;
               state_nxt = ST_STACK;
            end else if (start_ok && (cls_fault || fmt_bad)) begin
               // Faulting opcode is never executed, hence never traced
               accept_nxt = 1'b1;
               skip_nxt   = 1'b1;
               sr_nxt     = sr_enter;
               if (cls_fault && cls_fp)
                  frame_nxt = mk_frame(cls_vec, FRAME_FP_EA, instr.next_pc, instr.pc,
                                       instr.ea, sr_r, base);
               else if (cls_fault)
                  frame_nxt = mk_frame(cls_vec, FRAME_SHORT, instr.pc, instr.pc,
                                       32'h0000_0000, sr_r, base);
               else
                  frame_nxt = mk_frame(VEC_FORMAT, FRAME_SHORT, instr.pc, instr.pc,
                                       32'h0000_0000, sr_r, base);
               state_nxt  = ST_STACK;
            end else if (start_ok) begin
               accept_nxt  = 1'b1;
               tsel_nxt    = sr_r[SR_TSEL_HI:SR_TSEL_LO];
               flow_nxt    = instr.flow_change;
               stop_nxt    = instr.is_stop;
               next_pc_nxt = instr.next_pc;
               state_nxt   = ST_EXEC;
            end else if (irq_pending) begin
               grant_nxt = 1'b1;
            end
         end
         ST_EXEC: begin
            if (stop_sr_load)
               sr_nxt = stop_sr_value;
            if (instr_suspend) begin
               trace_due_nxt = trace_hit;
            end else if (forced_exc) begin
               // Forced exception is stacked elsewhere first; trace waits for frame_ack
               trace_due_nxt = trace_hit;
            end else if (instr_done) begin
               if (trace_hit || trace_due_r) begin
                  frame_nxt     = mk_frame(VEC_TRACE, FRAME_SHORT, next_pc_r, next_pc_r,
                                           32'h0000_0000,
                                           stop_sr_load ? stop_sr_value : sr_r,
                                           base);
                  sr_nxt        = {2'b00, exc_sr_tr,
                                   (stop_sr_load ? stop_sr_value[12:0] : sr_r[12:0])};
                  trace_due_nxt = 1'b0;
                  state_nxt     = ST_STACK;
               end else begin
                  stopped_nxt = stop_r;
                  state_nxt   = ST_IDLE;
               end
            end else if (trace_due_r && frame_ack) begin
               frame_nxt     = mk_frame(VEC_TRACE, FRAME_SHORT, next_pc_r, next_pc_r,
                                        32'h0000_0000, sr_r, base);
               sr_nxt        = sr_enter;
               trace_due_nxt = 1'b0;
               state_nxt     = ST_STACK;
            end
         end
         ST_STACK: begin
            if (frame_ack) begin
               frame_nxt.valid = 1'b0;
               state_nxt       = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_r     <= ST_IDLE;
         sr_r        <= SR_RESET;
         tsel_r      <= TRACE_OFF;
         flow_r      <= 1'b0;
         stop_r      <= 1'b0;
         trace_due_r <= 1'b0;
         next_pc_r   <= 32'h0000_0000;
         frame_r     <= '0;
         accept_r    <= 1'b0;
         skip_r      <= 1'b0;
         grant_r     <= 1'b0;
         stopped_r   <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         sr_r        <= sr_nxt;
         tsel_r      <= tsel_nxt;
         flow_r      <= flow_nxt;
         stop_r      <= stop_nxt;
         trace_due_r <= trace_due_nxt;
         next_pc_r   <= next_pc_nxt;
         frame_r     <= frame_nxt;
         accept_r    <= accept_nxt;
         skip_r      <= skip_nxt;
         grant_r     <= grant_nxt;
         stopped_r   <= stopped_nxt;
      end
   end

   // Outputs straight from flip-flops, except busy, which is decoded from state_r
   assign instr_accept          = accept_r;
   assign instr_skip            = skip_r;
   assign irq_grant             = grant_r;   // Only when no trace is outstanding
   assign stop_enter            = stopped_r; // Traced stop never reaches here
   assign processor_status_word = sr_r;
   assign trace_select_high     = sr_r[SR_TSEL_HI];
   assign trace_select_low      = sr_r[SR_TSEL_LO];
   assign frame_out             = frame_r;
   assign busy                  = state_r != ST_IDLE;
endmodule : fault_trace_exc
`default_nettype wire

// ==== hdl/fault_trace_pkg.sv ====
// Package for the instruction fault and trace exception unit.
// Assumes a 16-bit opcode word, 32-bit addresses and a 16-bit status word.
package fault_trace_pkg;
   // Vector numbers
   localparam logic [7:0] VEC_ILLEGAL   = 8'h04;
   localparam logic [7:0] VEC_PRIV      = 8'h08;
   localparam logic [7:0] VEC_TRACE     = 8'h09;
   localparam logic [7:0] VEC_LINE_A    = 8'h0a;
   localparam logic [7:0] VEC_LINE_F    = 8'h0b;
   localparam logic [7:0] VEC_FORMAT    = 8'h0e;
   // Opcode classes in bits 15:12
   localparam logic [3:0] NIB_LINE_A    = 4'ha;
   localparam logic [3:0] NIB_LINE_F    = 4'hf;
   // Status word field positions
   localparam int         SR_TSEL_HI    = 15;
   localparam int         SR_TSEL_LO    = 14;
   localparam int         SR_SUPER      = 13;
   localparam logic [15:0] SR_RESET     = 16'h2700;
   // Trace select encodings
   localparam logic [1:0] TRACE_OFF     = 2'h0;
   localparam logic [1:0] TRACE_FLOW    = 2'h1;
   localparam logic [1:0] TRACE_ALL     = 2'h2;
   // Stack frame kinds
   localparam logic [3:0] FRAME_SHORT   = 4'h0;
   localparam logic [3:0] FRAME_FP_EA   = 4'h4;
   localparam logic [3:0] FRAME_FMT_OK_MASK = 4'h0;

   // One instruction offered by the decoder
   typedef struct packed {
      logic        valid;
      logic [15:0] opcode;
      logic        legal;         // Matches a valid instruction
      logic        creg_undef;    // Control-register move with undefined register field
      logic        fp_unimpl;     // Family floating-point op not built here
      logic        privileged;
      logic        flow_change;   // Branch, jump, trap, return or status write
      logic        is_stop;
      logic        is_exc_return;
      logic [31:0] pc;
      logic [31:0] next_pc;
      logic [31:0] ea;
   } instr_info_type;

   // Exception request handed to the stacking sequencer
   typedef struct packed {
      logic        valid;
      logic [7:0]  vector;
      logic [3:0]  frame;
      logic [31:0] stacked_pc;
      logic [31:0] fault_pc;
      logic [31:0] ea;
      logic [15:0] saved_sr;
      logic [31:0] handler_addr;
   } exc_frame_type;

   // Vector fetch address: base plus four times the vector number
   function automatic logic [31:0] vector_addr(input logic [31:0] base,
                                               input logic [7:0]  vec);
      vector_addr = base + {22'h000000, vec, 2'h0};
   endfunction : vector_addr
endpackage : fault_trace_pkg

// ==== hdl/opcode_classifier.sv ====
// Classifies one decoded instruction into its fault vector.
// Assumes the decoder's legal, privilege and floating-point flags are valid with the word.
`timescale 1ns/1ps
`default_nettype none
module opcode_classifier
   import fault_trace_pkg::*;
(
   input  wire instr_info_type instr,
   input  wire logic           super_mode,
   output logic                fault,
   output logic [7:0]          vector,
   output logic                fp_frame
);
   // Opcode nibble tests
   wire       line_a   = instr.opcode[15:12] == NIB_LINE_A;
   wire       line_f   = instr.opcode[15:12] == NIB_LINE_F;
   wire       illegal  = (!instr.legal && !line_a && !line_f) || instr.creg_undef;
   wire       f_fault  = line_f && (!instr.legal || instr.fp_unimpl);
   wire       priv_bad = instr.legal && instr.privileged && !super_mode;

   // Priority: opcode faults first, then privilege
   assign fault    = instr.valid && (line_a || f_fault || illegal || priv_bad);
   assign vector   = line_a   ? VEC_LINE_A :
                     f_fault  ? VEC_LINE_F :
                     illegal  ? VEC_ILLEGAL :
                                VEC_PRIV;
   assign fp_frame = line_f && instr.legal && instr.fp_unimpl;
endmodule : opcode_classifier
`default_nettype wire

// ==== hdl/trace_qualifier.sv ====
// Decides whether a completed instruction is to be traced.
// Assumes the trace select bits were latched when the instruction began.
`timescale 1ns/1ps
`default_nettype none
module trace_qualifier
   import fault_trace_pkg::*;
(
   input  wire logic [1:0] tsel,
   input  wire logic       flow_change,
   output logic            take_trace
);
   // Encoding of the two select bits; reserved code never traces
   assign take_trace = (tsel == TRACE_ALL) ||
                       (tsel == TRACE_FLOW && flow_change);
endmodule : trace_qualifier
`default_nettype wire

// ==== tb/fault_trace_exc_assertions.sv ====
// Checker for the fault and trace unit, watching its ports only.
// Assumes the decoder holds instr steady through the accept cycle.
`timescale 1ns/1ps
`default_nettype none
module fault_trace_exc_assertions
   import fault_trace_pkg::*;
(
   input wire logic           mclk,
   input wire logic           arst_n,
   input wire instr_info_type instr,
   input wire logic           instr_done,
   input wire logic           format_valid,
   input wire logic [31:0]    vector_table_base,
   input wire logic           frame_ack,
   input wire logic           instr_accept,
   input wire logic           instr_skip,
   input wire logic           irq_grant,
   input wire logic [15:0]    processor_status_word,
   input wire exc_frame_type  frame_out
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Shorthands for the accept cycle of a skipped word
   wire logic       sk  = instr_accept && instr_skip;
   wire logic [3:0] nib = instr.opcode[15:12];
   wire logic       oth = nib != NIB_LINE_A && nib != NIB_LINE_F;
   wire logic       ok  = instr.legal && !instr.creg_undef && oth;
   wire logic [7:0] vec = frame_out.vector;
   wire logic [1:0] ts  = processor_status_word[15:14];
   // Trace-all word accepted and completed in the next cycle
   sequence s_all_done;
      instr_accept && !instr_skip && ts == TRACE_ALL ##1 instr_done;
   endsequence
   a_line_a_vec: assert property (sk && nib == NIB_LINE_A |-> vec == VEC_LINE_A)
      else $error("wrong A-line vector");
   a_line_f_vec: assert property (sk && nib == NIB_LINE_F && (!instr.legal || instr.fp_unimpl)
      |-> vec == VEC_LINE_F) else $error("wrong F-line vector");
   a_illegal_vec: assert property (sk && oth && (!instr.legal || instr.creg_undef)
      |-> vec == VEC_ILLEGAL) else $error("wrong illegal vector");
   a_fault_frame: assert property (sk |-> frame_out.valid && ts == TRACE_OFF
      && processor_status_word[SR_SUPER] && frame_out.saved_sr == $past(processor_status_word)
      && frame_out.stacked_pc == (instr.fp_unimpl ? instr.next_pc : instr.pc))
      else $error("bad fault frame");
   a_priv_vec: assert property (sk && ok && instr.privileged
      && !$past(processor_status_word[SR_SUPER]) |-> vec == VEC_PRIV) else $error("bad priv");
   a_format_vec: assert property (sk && ok && instr.is_exc_return && !format_valid
      && $past(processor_status_word[SR_SUPER]) |-> vec == VEC_FORMAT
      && frame_out.frame == FRAME_SHORT) else $error("bad format fault");
   a_trace_all: assert property (s_all_done |=> frame_out.valid && vec == VEC_TRACE
      && ts == TRACE_OFF && processor_status_word[SR_SUPER]) else $error("trace missed");
   a_vec_fetch: assert property (frame_out.valid |-> frame_out.handler_addr
      == vector_table_base + {22'h000000, vec, 2'h0}) else $error("bad handler address");
   a_irq_waits: assert property (frame_out.valid |-> !irq_grant)
      else $error("interrupt before frame done");
   a_ack_idle: assert property (frame_out.valid && frame_ack && vec != VEC_TRACE
      |=> !frame_out.valid) else $error("frame after fault");
endmodule : fault_trace_exc_assertions
bind fault_trace_exc fault_trace_exc_assertions chk (.mclk, .arst_n, .instr, .instr_done,
   .format_valid, .vector_table_base, .frame_ack, .instr_accept, .instr_skip, .irq_grant,
   .processor_status_word, .frame_out);
`default_nettype wire

// ==== tb/decoder_model.sv ====
// Decoder and breakpoint termination model facing the fault and trace unit.
// Assumes the bench calls its tasks; lines change only after rising edges.
`timescale 1ns/1ps
`default_nettype none
module decoder_model
   import fault_trace_pkg::*;
(
   input  wire logic         mclk,
   input  wire logic         instr_accept,
   output var instr_info_type instr,
   output logic              instr_start,
   output logic              bkpt_ack_cycle,
   output logic              transfer_done_ack,
   output logic              transfer_fault_ack
);
   // Idle lines at time zero
   initial begin
      instr = '0;
      {instr_start, bkpt_ack_cycle, transfer_done_ack, transfer_fault_ack} = 4'h0;
   end
   // Hold a word until taken or 20 cycles pass, then scramble the released lines
   task automatic offer(input instr_info_type w, output bit ok);
      @(posedge mclk);
      instr <= w;
      instr_start <= 1'b1;
      ok = 1'b0;
      for (int k = 0; k < 20 && !ok; k++) begin
         @(negedge mclk);
         ok = instr_accept === 1'b1;
      end
      @(posedge mclk);
      instr <= ~w;
      instr_start <= 1'b0;
   endtask : offer
   // Breakpoint cycle ended by either acknowledge after a lag
   task automatic bkpt(input bit err, input int lag);
      @(posedge mclk) bkpt_ack_cycle <= 1'b1;
      repeat (lag) @(posedge mclk);
      transfer_done_ack <= !err;
      transfer_fault_ack <= err;
      @(posedge mclk) {bkpt_ack_cycle, transfer_done_ack, transfer_fault_ack} <= 3'h0;
   endtask : bkpt
endmodule : decoder_model
`default_nettype wire

// ==== tb/fault_trace_exc_tb.sv ====
// Bench for the fault and trace unit: fault vectors, trace modes and ordering.
// Assumes decoder_model on the far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module fault_trace_exc_tb import fault_trace_pkg::*;;
   localparam logic [31:0] PC = 32'h1000, NPC = 32'h1004, EA = 32'h2000, VB = 32'h400;
   localparam logic [6:0]  LG = 7'h40, CR = 7'h20, FP = 7'h10, PV = 7'h08, FL = 7'h04;
   logic           mclk, arst_n, instr_start, instr_done, instr_suspend, forced_exc;
   logic           irq_pending, stop_sr_load, format_valid, frame_ack, instr_accept;
   logic           instr_skip, irq_grant, stop_enter, busy, bkpt_ack_cycle;
   logic           transfer_done_ack, transfer_fault_ack, trace_select_high, trace_select_low;
   logic [15:0]    stop_sr_value, processor_status_word;
   instr_info_type instr;
   exc_frame_type  frame_out;
   int             fail_count = 0, cmp_count = 0, cyc = 0, stops = 0, grants = 0, n;
   fault_trace_exc i_fault_trace_exc (.mclk, .arst_n, .instr, .instr_start, .instr_done,
      .instr_suspend, .forced_exc, .irq_pending, .stop_sr_load, .stop_sr_value,
      .bkpt_ack_cycle, .transfer_done_ack, .transfer_fault_ack, .return_format(4'h0),
      .format_valid, .vector_table_base(VB), .frame_ack, .instr_accept, .instr_skip,
      .irq_grant, .stop_enter, .processor_status_word, .trace_select_high,
      .trace_select_low, .frame_out, .busy);
   decoder_model i_decoder_model (.mclk, .instr_accept, .instr, .instr_start, .bkpt_ack_cycle,
      .transfer_done_ack, .transfer_fault_ack);
   // Clock, cycle ceiling and pulse counters
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      stops += int'(stop_enter === 1'b1);
      grants += int'(irq_grant === 1'b1);
      if (cyc == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic instr_info_type w(input logic [15:0] op, input logic [6:0] f);
      w = {1'b1, op, f, PC, NPC, EA};
   endfunction : w
   // Offer a word, then play its execution events by mode
   task automatic run(input instr_info_type x, input int mode, input logic [15:0] v = 16'h0);
      bit ok;
      i_decoder_model.offer(x, ok);
      check(ok, 1'b1);
      if (mode == 2) begin
         @(posedge mclk) instr_suspend <= 1'b1;
         @(posedge mclk) instr_suspend <= 1'b0;
         @(negedge mclk) check(frame_out.valid, 1'b0);
         @(posedge mclk);
      end
      if (mode == 3) begin
         forced_exc <= 1'b1;
         @(posedge mclk) forced_exc <= 1'b0;
         @(negedge mclk) check(frame_out.valid, 1'b0);
         @(posedge mclk) frame_ack <= 1'b1;
         @(posedge mclk) frame_ack <= 1'b0;
      end
      if (mode == 4) begin
         stop_sr_load <= 1'b1;
         stop_sr_value <= v;
         @(posedge mclk) stop_sr_load <= 1'b0;
      end
      if (mode != 0 && mode != 3) begin
         instr_done <= 1'b1;
         irq_pending <= mode == 5;
         @(posedge mclk) instr_done <= 1'b0;
      end
   endtask : run
   // Wait for a frame, compare it, acknowledge it, expect idle
   task automatic expect_frame(input logic [7:0] v, input logic [31:0] spc,
                               input logic [15:0] sr, input logic [3:0] fr = FRAME_SHORT);
      @(negedge mclk);
      for (int k = 0; k < 10 && frame_out.valid !== 1'b1; k++) @(negedge mclk);
      check(frame_out.vector, v);
      check(frame_out.frame, fr);
      check(frame_out.stacked_pc, spc);
      check(frame_out.saved_sr, sr);
      check(frame_out.handler_addr, VB + {22'h0, v, 2'h0});
      check({trace_select_high, trace_select_low, processor_status_word[15:13]}, 5'h01);
      if (fr == FRAME_FP_EA) check(frame_out.ea, EA);
      if (fr == FRAME_FP_EA) check(frame_out.fault_pc, PC);
      @(posedge mclk) frame_ack <= 1'b1;
      @(posedge mclk) frame_ack <= 1'b0;
      @(negedge mclk) check({frame_out.valid, busy}, 2'h0);
   endtask : expect_frame
   // Untraced stop loads the status word
   task automatic set_sr(input logic [15:0] v);
      n = stops;
      run(w(16'h4e72, LG | PV | 7'h02), 4, v);
      repeat (3) @(negedge mclk);
      check(stops - n, 1);
      check(processor_status_word, v);
   endtask : set_sr
   task report_and_stop;
      $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      {arst_n, instr_done, instr_suspend, forced_exc, irq_pending} = 5'h0;
      {stop_sr_load, stop_sr_value, format_valid, frame_ack} = 19'h0;
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk) check(processor_status_word, SR_RESET);
      run(w(16'h4afc, 7'h0), 0);
      expect_frame(VEC_ILLEGAL, PC, SR_RESET);
      run(w(16'h4e7a, LG | CR), 0);
      expect_frame(VEC_ILLEGAL, PC, SR_RESET);
      run(w(16'ha000, 7'h0), 0);
      expect_frame(VEC_LINE_A, PC, SR_RESET);
      run(w(16'hf800, 7'h0), 0);
      expect_frame(VEC_LINE_F, PC, SR_RESET);
      run(w(16'hf200, LG | FP), 0);
      expect_frame(VEC_LINE_F, NPC, SR_RESET, FRAME_FP_EA);
      run(w(16'h4e73, LG | PV | FL | 7'h01), 0);
      expect_frame(VEC_FORMAT, PC, SR_RESET);
      i_decoder_model.bkpt(1'b0, 0);
      expect_frame(VEC_ILLEGAL, ~PC, SR_RESET);
      i_decoder_model.bkpt(1'b1, 3);
      expect_frame(VEC_ILLEGAL, ~PC, SR_RESET);
      set_sr(16'h0000);
      run(w(16'h46fc, LG | PV | FL), 0);
      expect_frame(VEC_PRIV, PC, 16'h0000);
      set_sr(16'ha000);
      run(w(16'h4e71, LG), 1);
      expect_frame(VEC_TRACE, NPC, 16'ha000);
      set_sr(16'h6000);
      run(w(16'h4e71, LG), 1);
      repeat (3) @(negedge mclk) check(frame_out.valid, 1'b0);
      run(w(16'h6000, LG | FL), 1);
      expect_frame(VEC_TRACE, NPC, 16'h6000);
      set_sr(16'he000);
      run(w(16'h6000, LG | FL), 1);
      repeat (3) @(negedge mclk) check(frame_out.valid, 1'b0);
      set_sr(16'ha000);
      run(w(16'ha000, 7'h0), 0);
      expect_frame(VEC_LINE_A, PC, 16'ha000);
      set_sr(16'ha000);
      run(w(16'h4e71, LG), 2);
      expect_frame(VEC_TRACE, NPC, 16'ha000);
      set_sr(16'ha000);
      run(w(16'h4e71, LG), 3);
      expect_frame(VEC_TRACE, NPC, 16'ha000);
      set_sr(16'ha000);
      n = grants;
      run(w(16'h4e71, LG), 5);
      expect_frame(VEC_TRACE, NPC, 16'ha000);
      repeat (3) @(negedge mclk);
      check(grants > n, 1'b1);
      set_sr(16'ha000);
      n = stops;
      run(w(16'h4e72, LG | PV | 7'h02), 4, 16'h2300);
      expect_frame(VEC_TRACE, NPC, 16'h2300);
      check(stops - n, 0);
      report_and_stop();
   end
endmodule : fault_trace_exc_tb
`default_nettype wire
